// ===== tb/wdt_reset_sink.sv
/* wdt_reset_sink: external reset circuit, measures the overflow pin pulse.
 assumes one clock, pin active low. */
`timescale 1ns/1ps
module wdt_reset_sink (
  // clock and reset
  input wire clk,
  input wire resetn,
  // pin and measure
  input wire overflow_out_n,
  output reg [15:0] pulse_len
);
  reg [15:0] run_len;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run_len <= 16'h0000;
      pulse_len <= 16'h0000;
    end else begin
      run_len <= overflow_out_n ? 16'h0000 : run_len + 16'h0001;
      if (overflow_out_n && run_len != 16'h0000) begin
        pulse_len <= run_len;
      end
    end
  end
endmodule // wdt_reset_sink

// ===== tb/wdt_timer_properties.sv
/* wdt_timer_checker: port assertions for wdt_timer.
 assumes a bind to wdt_timer, one clock domain. */
`timescale 1ns/1ps
`include "wdt_defines.vh"
module wdt_timer_checker #(
  parameter OVF_CYCLES = 128,
  parameter RST_CYCLES = 512
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // register port
  input wire [31:0] addr,
  input wire rd_byte,
  input wire [7:0] rdata,
  input wire rvalid,
  // standby request and outputs
  input wire standby_request,
  input wire standby_allow,
  input wire standby_wake,
  input wire overflow_out_n,
  input wire interval_interrupt,
  input wire chip_reset_por,
  input wire chip_reset_manual
);
  reg [15:0] low_cnt;
  reg [15:0] rst_cnt;
  wire rst_any = chip_reset_por | chip_reset_manual;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // length of current low pin and chip reset runs
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_cnt <= 16'h0000;
      rst_cnt <= 16'h0000;
    end else begin
      low_cnt <= overflow_out_n ? 16'h0000 : low_cnt + 16'h0001;
      rst_cnt <= rst_any ? rst_cnt + 16'h0001 : 16'h0000;
    end
  end
  chk_pin_low_len: assert property ($rose(overflow_out_n) |-> low_cnt == OVF_CYCLES)
    else $error("pin low time");
  chk_chip_rst_len: assert property ($fell(rst_any) |-> rst_cnt == RST_CYCLES)
    else $error("chip reset time");
  chk_rst_with_pin: assert property ($rose(rst_any) |-> $fell(overflow_out_n))
    else $error("chip reset not with pin");
  chk_rst_type_excl: assert property (!(chip_reset_por && chip_reset_manual))
    else $error("both reset types");
  chk_pin_no_int: assert property ($fell(overflow_out_n) |-> !interval_interrupt)
    else $error("interrupt in watchdog mode");
  chk_int_single: assert property (interval_interrupt |=> !interval_interrupt)
    else $error("interrupt too long");
  chk_read_answer: assert property (rd_byte |=> rvalid)
    else $error("no read answer");
  chk_rctl_fixed: assert property (rd_byte && addr == `WDT_ADDR_RSTR |=> rdata[5:0] == 6'h0F)
    else $error("reset control fixed bits");
  chk_ctl_fixed: assert property (rd_byte && addr == `WDT_ADDR_CSR |=> rdata[4:3] == 2'h3)
    else $error("control fixed bits");
  chk_standby_gate: assert property (standby_allow |-> $past(standby_request))
    else $error("standby allowed unasked");
  chk_wake_pulse: assert property (standby_wake |=> !standby_wake)
    else $error("wake too long");
endmodule // wdt_timer_checker

// ===== tb/wdt_timer_test.sv
/* wdt_timer_test: self-checking bench for wdt_timer.
 assumes the checker and reset sink files compiled first. */
`timescale 1ns/1ps
`include "wdt_defines.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
`define WAITON(c, lim) begin n = 0; while (!(c) && n < (lim)) begin @(negedge clk); n++; end \
  if (n >= (lim)) begin error_cnt++; wrap_up; end end
module wdt_timer_test;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg external_reset_pin_n = 1'b1;
  reg standby_active = 1'b0;
  reg standby_request = 1'b0;
  reg nmi_request = 1'b0;
  reg [31:0] addr = 32'h00000000;
  reg wr_word = 1'b0;
  reg wr_byte = 1'b0;
  reg [15:0] wdata = 16'h0000;
  reg rd_byte = 1'b0;
  wire [7:0] rdata;
  wire rvalid, overflow_out_n, interval_interrupt, chip_reset_por, chip_reset_manual;
  wire standby_allow, standby_wake;
  wire [15:0] pulse_len;
  int error_cnt = 0;
  int checked = 0;
  int n;
  int s;
  int t;
  reg [7:0] p;
  always #2 clk = ~clk;
  wdt_timer u_wdt_timer (.clk, .resetn, .external_reset_pin_n, .standby_active,
    .standby_request, .nmi_request, .addr, .wr_word, .wr_byte, .wdata, .rd_byte, .rdata,
    .rvalid, .overflow_out_n, .interval_interrupt, .chip_reset_por, .chip_reset_manual,
    .standby_allow, .standby_wake);
  wdt_reset_sink u_wdt_reset_sink (.clk, .resetn, .overflow_out_n, .pulse_len);
  function int div_of(input int k);
    return k == 0 ? 2 : k < 6 ? 32 << k : 1024 << (k - 4);
  endfunction
  task wrap_up;
    $display("checks=%0d errors=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task wr(input [31:0] a, input [15:0] d, input bt);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_word = 1'b1;
    wr_byte = bt;
    @(negedge clk);
    wr_word = 1'b0;
    wr_byte = 1'b0;
  endtask
  task rd(input [31:0] a, input [7:0] e);
    @(negedge clk);
    addr = a;
    rd_byte = 1'b1;
    @(negedge clk);
    rd_byte = 1'b0;
    `CHK(rvalid, 1'b1)
    `CHK(rdata, e)
  endtask
  initial begin
    void'($urandom(376));
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    rd(`WDT_ADDR_CSR, 8'h18);
    rd(`WDT_ADDR_CNT, 8'h00);
    rd(`WDT_ADDR_RSTR, 8'h0F);
    rd(32'hFFFF8614, 8'h00);
    // interval mode, every divider, random preload
    for (s = 0; s < 8; s++) begin
      wr(`WDT_ADDR_CSR, {`WDT_KEY_CSR, 8'h18 | s[7:0]}, 1'b0);
      wr(`WDT_ADDR_CSR, {`WDT_KEY_CNT, 8'h55}, 1'b0);
      rd(`WDT_ADDR_CNT, 8'h00);
      wr(`WDT_ADDR_CSR, {`WDT_KEY_CSR, 8'h38 | s[7:0]}, 1'b0);
      p = 8'hFC + 8'($urandom % 4);
      wr(`WDT_ADDR_CSR, {`WDT_KEY_CNT, p}, 1'b0);
      `WAITON(interval_interrupt, 40000)
      `CHK(n >= (255 - p) * div_of(s) && n <= (256 - p) * div_of(s) + 4, 1'b1)
      rd(`WDT_ADDR_CSR, 8'hB8 | s[7:0]);
      rd(`WDT_ADDR_RSTR, 8'h0F);
      wr(`WDT_ADDR_CSR, {`WDT_KEY_CSR, 8'h38 | s[7:0]}, 1'b0);
      rd(`WDT_ADDR_CSR, 8'h38 | s[7:0]);
      wr(`WDT_ADDR_CSR, {`WDT_KEY_CSR, 8'h18 | s[7:0]}, 1'b0);
    end
    // refused writes
    wr(`WDT_ADDR_CSR, {`WDT_KEY_CSR, 8'h18}, 1'b0);
    wr(`WDT_ADDR_CSR, {`WDT_KEY_CSR, 8'h78}, 1'b1);
    wr(`WDT_ADDR_CSR, {8'h3C, 8'h78}, 1'b0);
    rd(`WDT_ADDR_CSR, 8'h18);
    // watchdog overflow, no chip reset; kicks first
    wr(`WDT_ADDR_CSR, {`WDT_KEY_CSR, 8'h78}, 1'b0);
    for (t = 0; t < 4; t++) begin
      repeat (100 + $urandom % 300) @(negedge clk);
      wr(`WDT_ADDR_CSR, {`WDT_KEY_CNT, 8'h00}, 1'b0);
      `CHK(overflow_out_n, 1'b1)
    end
    wr(`WDT_ADDR_CSR, {`WDT_KEY_CNT, 8'hF0}, 1'b0);
    `WAITON(!overflow_out_n, 100)
    `WAITON(overflow_out_n, 200)
    @(negedge clk);
    `CHK(pulse_len, 16'(`WDT_OVF_OUT_CYC))
    rd(`WDT_ADDR_CSR, 8'h18);
    rd(`WDT_ADDR_CNT, 8'h00);
    rd(`WDT_ADDR_RSTR, 8'h8F);
    wr(`WDT_ADDR_RSTW, {`WDT_KEY_RCLR, `WDT_RCLR_LOW}, 1'b0);
    rd(`WDT_ADDR_RSTR, 8'h0F);
    // chip reset, both types
    for (t = 0; t < 2; t++) begin
      wr(`WDT_ADDR_RSTW, {`WDT_KEY_RSET, 8'h40 | (t[7:0] << 5)}, 1'b0);
      rd(`WDT_ADDR_RSTR, 8'h4F);
      wr(`WDT_ADDR_CSR, {`WDT_KEY_CSR, 8'h7F}, 1'b0);
      wr(`WDT_ADDR_CSR, {`WDT_KEY_CNT, 8'hFF}, 1'b0);
      `WAITON(chip_reset_por | chip_reset_manual, 8300)
      `CHK(chip_reset_manual, t[0])
      `CHK(chip_reset_por, !t[0])
      `WAITON(!chip_reset_por && !chip_reset_manual, 600)
      `CHK(n, `WDT_CHIP_RST_CYC)
      rd(`WDT_ADDR_CSR, 8'h7F);
      rd(`WDT_ADDR_RSTR, 8'hCF);
      wr(`WDT_ADDR_RSTW, {`WDT_KEY_RCLR, `WDT_RCLR_LOW}, 1'b0);
      wr(`WDT_ADDR_CSR, {`WDT_KEY_CSR, 8'h18}, 1'b0);
    end
    // external reset lands on the overflow cycle
    wr(`WDT_ADDR_RSTW, {`WDT_KEY_RSET, 8'h40}, 1'b0);
    wr(`WDT_ADDR_CSR, {`WDT_KEY_CSR, 8'h78}, 1'b0);
    wr(`WDT_ADDR_CSR, {`WDT_KEY_CNT, 8'hFF}, 1'b0);
    external_reset_pin_n = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(overflow_out_n, 1'b1)
    `CHK(chip_reset_por, 1'b0)
    external_reset_pin_n = 1'b1;
    rd(`WDT_ADDR_RSTR, 8'h0F);
    // standby gate and recovery
    standby_request = 1'b1;
    wr(`WDT_ADDR_CSR, {`WDT_KEY_CSR, 8'h38}, 1'b0);
    @(negedge clk);
    `CHK(standby_allow, 1'b0)
    wr(`WDT_ADDR_CSR, {`WDT_KEY_CSR, 8'h18}, 1'b0);
    @(negedge clk);
    `CHK(standby_allow, 1'b1)
    standby_request = 1'b0;
    standby_active = 1'b1;
    nmi_request = 1'b1;
    @(negedge clk);
    nmi_request = 1'b0;
    `WAITON(standby_wake, 700)
    `CHK(n >= 255 * div_of(0) - 2 && n <= 256 * div_of(0) + 4, 1'b1)
    standby_active = 1'b0;
    wrap_up;
  end
endmodule // wdt_timer_test
bind wdt_timer wdt_timer_checker #(.OVF_CYCLES(OVF_CYCLES), .RST_CYCLES(RST_CYCLES)) u_chk (
  .clk, .resetn, .addr, .rd_byte, .rdata, .rvalid, .standby_request, .standby_allow,
  .standby_wake, .overflow_out_n, .interval_interrupt, .chip_reset_por, .chip_reset_manual);

// ===== verilog/wdt_defines.vh
/*
 watchdog interval timer constants: offsets, fields, reset values, keys, timing counts.
 assumes inclusion by bare name from the design files.
*/
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH
`define WDT_ADDR_CSR 32'hFFFF8610
`define WDT_ADDR_CNT 32'hFFFF8611
`define WDT_ADDR_RSTW 32'hFFFF8612
`define WDT_ADDR_RSTR 32'hFFFF8613
`define WDT_KEY_CNT 8'h5A
`define WDT_KEY_CSR 8'hA5
`define WDT_KEY_RCLR 8'hA5
`define WDT_KEY_RSET 8'h5A
`define WDT_RCLR_LOW 8'h00
`define WDT_CSR_OVF 7
`define WDT_CSR_MODE 6
`define WDT_CSR_RUN 5
`define WDT_RST_WATCHDOG_OVERFLOW_FLAG 7
`define WDT_RST_CHIP_RESET_ENABLE 6
`define WDT_RST_RESET_TYPE_SELECT 5
`define WDT_CSR_RESET 8'h18
`define WDT_CSR_ONES 8'h18
`define WDT_CNT_RESET 8'h00
`define WDT_RST_RESET 8'h1F
`define WDT_RST_ONES 8'h0F
`define WDT_OVF_OUT_CYC 128
`define WDT_CHIP_RST_CYC 512
`define WDT_CNT_MAX 8'hFF
`endif

// ===== verilog/wdt_prescaler.v
/*
 wdt_prescaler: free-running divider giving a one-cycle tick at clk/2 .. clk/8192.
 assumes one clock; select is stable while the counter runs.
*/
`timescale 1ns/1ps
module wdt_prescaler #(
  parameter WIDTH = 13
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // control
  input wire clear,
  input wire [2:0] sel,
  // tick
  output reg tick
);
  reg [WIDTH-1:0] div_reg;
  reg [WIDTH-1:0] mask;

  // division mask per code
  always @* begin
    case (sel)
      3'h0: mask = 13'h0001;
      3'h1: mask = 13'h003F;
      3'h2: mask = 13'h007F;
      3'h3: mask = 13'h00FF;
      3'h4: mask = 13'h01FF;
      3'h5: mask = 13'h03FF;
      3'h6: mask = 13'h0FFF;
      default: mask = 13'h1FFF;
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= 13'h0000;
      tick <= 1'b0;
    end else if (clear) begin
      div_reg <= 13'h0000;
      tick <= 1'b0;
    end else begin
      div_reg <= div_reg + 13'h0001;
      tick <= ((div_reg & mask) == mask);
    end
  end
endmodule // wdt_prescaler

// ===== verilog/wdt_timer.v
/*
 wdt_timer: watchdog / interval timer with keyed word writes and byte reads.
 assumes a simple cpu port: one-cycle strobes, address held with the strobe,
 standby controller and reset distribution outside.
*/
`timescale 1ns/1ps
`include "wdt_defines.vh"
module wdt_timer #(
  parameter OVF_CYCLES = `WDT_OVF_OUT_CYC,
  parameter RST_CYCLES = `WDT_CHIP_RST_CYC
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // external reset pin and standby state
  input wire external_reset_pin_n,
  input wire standby_active,
  input wire standby_request,
  input wire nmi_request,
  // cpu register port
  input wire [31:0] addr,
  input wire wr_word,
  input wire wr_byte,
  input wire [15:0] wdata,
  input wire rd_byte,
  output reg [7:0] rdata,
  output reg rvalid,
  // outputs
  output reg overflow_out_n,
  output reg interval_interrupt,
  output reg chip_reset_por,
  output reg chip_reset_manual,
  output reg standby_allow,
  output reg standby_wake
);
  reg [7:0] count_reg;
  reg interval_overflow_flag;
  reg mode_select_bit;
  reg timer_run_enable;
  reg [2:0] clock_divider_select;
  reg watchdog_overflow_flag;
  reg chip_reset_enable;
  reg reset_type_select;
  reg ovf_read_reg;
  reg watchdog_overflow_flag_read_reg;
  reg [7:0] ovf_cnt_reg;
  reg [9:0] rst_cnt_reg;
  reg recov_reg;
  wire tick;
  wire ext_rst;
  wire counting;
  wire overflow;
  wire wd_ovf;
  wire it_ovf;
  wire wr_cnt;
  wire wr_csr;
  wire wr_rclr;
  wire wr_rset;
  wire self_clear;
  wire [7:0] csr_view;
  wire [7:0] rst_view;

  assign ext_rst = !external_reset_pin_n || standby_active;
  assign counting = timer_run_enable || recov_reg;
  assign wr_cnt = wr_word && !wr_byte && addr == `WDT_ADDR_CSR
                  && wdata[15:8] == `WDT_KEY_CNT;
  assign wr_csr = wr_word && !wr_byte && addr == `WDT_ADDR_CSR
                  && wdata[15:8] == `WDT_KEY_CSR;
  assign wr_rclr = wr_word && !wr_byte && addr == `WDT_ADDR_RSTW
                   && wdata[15:8] == `WDT_KEY_RCLR
                   && wdata[7:0] == `WDT_RCLR_LOW;
  assign wr_rset = wr_word && !wr_byte && addr == `WDT_ADDR_RSTW
                   && wdata[15:8] == `WDT_KEY_RSET;
  // tick lost to a coincident write
  assign overflow = counting && tick && !wr_cnt
                    && count_reg == `WDT_CNT_MAX;
  assign wd_ovf = overflow && mode_select_bit && timer_run_enable;
  assign it_ovf = overflow && !mode_select_bit && timer_run_enable;
  assign self_clear = wd_ovf && !chip_reset_enable;
  assign csr_view = {interval_overflow_flag, mode_select_bit, timer_run_enable,
                     2'b11, clock_divider_select} | `WDT_CSR_ONES;
  assign rst_view = {watchdog_overflow_flag, chip_reset_enable, 2'b00, 4'hF}
                    | `WDT_RST_ONES;

  wdt_prescaler #(
    .WIDTH(13)
  ) u_prescaler (
    .clk(clk),
    .resetn(resetn),
    .clear(!counting || !external_reset_pin_n),
    .sel(clock_divider_select),
    .tick(tick)
  );

  // counter
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= `WDT_CNT_RESET;
    end else if (!external_reset_pin_n || self_clear) begin
      count_reg <= `WDT_CNT_RESET;
    end else if (!counting) begin
      count_reg <= `WDT_CNT_RESET;
    end else if (wr_cnt) begin
      count_reg <= wdata[7:0];
    end else if (tick) begin
      count_reg <= count_reg + 8'h01;
    end
  end

  // control register
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      interval_overflow_flag <= 1'b0;
      mode_select_bit <= 1'b0;
      timer_run_enable <= 1'b0;
      clock_divider_select <= 3'h0;
      ovf_read_reg <= 1'b0;
    end else if (!external_reset_pin_n || self_clear) begin
      interval_overflow_flag <= 1'b0;
      mode_select_bit <= 1'b0;
      timer_run_enable <= 1'b0;
      clock_divider_select <= 3'h0;
      ovf_read_reg <= 1'b0;
    end else if (standby_active) begin
      interval_overflow_flag <= 1'b0;
      mode_select_bit <= 1'b0;
      timer_run_enable <= 1'b0;
    end else begin
      if (rd_byte && addr == `WDT_ADDR_CSR && interval_overflow_flag) begin
        ovf_read_reg <= 1'b1;
      end
      if (wr_csr) begin
        mode_select_bit <= wdata[`WDT_CSR_MODE];
        timer_run_enable <= wdata[`WDT_CSR_RUN];
        clock_divider_select <= wdata[2:0];
      end
      // set beats clear
      if (it_ovf) begin
        interval_overflow_flag <= 1'b1;
      end else if (wr_csr && ovf_read_reg && !wdata[`WDT_CSR_OVF]) begin
        interval_overflow_flag <= 1'b0;
        ovf_read_reg <= 1'b0;
      end
    end
  end

  // reset control register
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      watchdog_overflow_flag <= 1'b0;
      chip_reset_enable <= 1'b0;
      reset_type_select <= 1'b0;
      watchdog_overflow_flag_read_reg <= 1'b0;
    end else if (ext_rst) begin
      watchdog_overflow_flag <= 1'b0;
      chip_reset_enable <= 1'b0;
      reset_type_select <= 1'b0;
      watchdog_overflow_flag_read_reg <= 1'b0;
    end else begin
      if (rd_byte && addr == `WDT_ADDR_RSTR && watchdog_overflow_flag) begin
        watchdog_overflow_flag_read_reg <= 1'b1;
      end
      if (wr_rset) begin
        chip_reset_enable <= wdata[`WDT_RST_CHIP_RESET_ENABLE];
        reset_type_select <= wdata[`WDT_RST_RESET_TYPE_SELECT];
      end
      if (wd_ovf) begin
        watchdog_overflow_flag <= 1'b1;
      end else if (wr_rclr && watchdog_overflow_flag_read_reg) begin
        watchdog_overflow_flag <= 1'b0;
        watchdog_overflow_flag_read_reg <= 1'b0;
      end
    end
  end

  // overflow pin and chip reset pulses
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ovf_cnt_reg <= 8'h00;
      rst_cnt_reg <= 10'h000;
      overflow_out_n <= 1'b1;
      chip_reset_por <= 1'b0;
      chip_reset_manual <= 1'b0;
      interval_interrupt <= 1'b0;
    end else begin
      interval_interrupt <= it_ovf;
      if (wd_ovf && external_reset_pin_n) begin
        ovf_cnt_reg <= OVF_CYCLES[7:0] - 8'h01;
        overflow_out_n <= 1'b0;
      end else if (ovf_cnt_reg != 8'h00) begin
        ovf_cnt_reg <= ovf_cnt_reg - 8'h01;
      end else begin
        overflow_out_n <= 1'b1;
      end
      if (!external_reset_pin_n) begin
        rst_cnt_reg <= 10'h000;
        chip_reset_por <= 1'b0;
        chip_reset_manual <= 1'b0;
      end else if (wd_ovf && chip_reset_enable) begin
        rst_cnt_reg <= RST_CYCLES[9:0] - 10'h001;
        chip_reset_por <= !reset_type_select;
        chip_reset_manual <= reset_type_select;
      end else if (rst_cnt_reg != 10'h000) begin
        rst_cnt_reg <= rst_cnt_reg - 10'h001;
      end else begin
        chip_reset_por <= 1'b0;
        chip_reset_manual <= 1'b0;
      end
    end
  end

  // standby gating and recovery
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      recov_reg <= 1'b0;
      standby_allow <= 1'b0;
      standby_wake <= 1'b0;
    end else begin
      standby_allow <= standby_request && !timer_run_enable;
      standby_wake <= 1'b0;
      if (!standby_active) begin
        recov_reg <= 1'b0;
      end else if (nmi_request) begin
        recov_reg <= 1'b1;
      end else if (recov_reg && tick && count_reg == `WDT_CNT_MAX) begin
        recov_reg <= 1'b0;
        standby_wake <= 1'b1;
      end
    end
  end

  // byte read port
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= rd_byte;
      if (!rd_byte) begin
        rdata <= 8'h00;
      end else begin
        case (addr)
          `WDT_ADDR_CSR: rdata <= csr_view;
          `WDT_ADDR_CNT: rdata <= count_reg;
          `WDT_ADDR_RSTR: rdata <= rst_view;
          default: rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule // wdt_timer
